// *** design/remap_check.sv ***
`timescale 1ns/100ps
`default_nettype none
module remap_check #(
    parameter int LEVELS             = 4,
    parameter int HOST_ADDRESS_WIDTH = 48
) (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    output logic             irq,
    // translation request
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic [63:0] req_addr,
    input  wire logic        req_write,
    input  wire logic        req_zero_len,
    input  wire logic [1:0]  req_at,
    input  wire logic [15:0] req_requester_identifier,
    output logic             resp_valid,
    output logic             resp_ok,
    output logic      [63:0] resp_hpa,
    // table memory
    output logic             mem_req,
    output logic      [63:0] mem_addr,
    input  wire logic        mem_ready,
    input  wire logic        mem_valid,
    input  wire logic [63:0] mem_data,
    // interrupt remapping fault source
    input  wire logic        ir_fault_valid,
    output logic             ir_fault_ready,
    input  wire logic [7:0]  ir_fault_cause,
    input  wire logic [15:0] ir_requester_identifier,
    input  wire logic [15:0] ir_index,
    // fault record out
    output logic             fault_valid,
    output logic      [127:0] fault_record
);
    ////////////////////////////////////////////////////////////////////////////////
    localparam logic [63:0] HOST_MASK = ~(64'hffff_ffff_ffff_ffff << HOST_ADDRESS_WIDTH);

    typedef struct packed {
        remap_check_pkg::walk_state_e st;
        logic [remap_check_pkg::LVL_W-1:0] lvl;
        logic [63:0]  addr;
        logic         is_write;
        logic         zero_len;
        logic [1:0]   at;
        logic [15:0]  rid;
        logic [63:0]  table_base;
        logic [63:0]  mem_addr;
        logic [31:0]  ctrl;
        logic [63:0]  root;
        logic [1:0]   status;
        logic [1:0]   mask;
        logic         resp_valid;
        logic         resp_ok;
        logic [63:0]  resp_hpa;
        logic [127:0] record;
        logic         fault_valid;
        logic [31:0]  rdata;
    } state_s;

    state_s s_r;
    state_s s_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic int page_shift(input logic [remap_check_pkg::LVL_W-1:0] lvl);
        return remap_check_pkg::PAGE_SHIFT + remap_check_pkg::LEVEL_STRIDE * int'(lvl);
    endfunction

    function automatic logic [63:0] low_mask(input logic [remap_check_pkg::LVL_W-1:0] lvl);
        return ~(64'hffff_ffff_ffff_ffff << page_shift(lvl));
    endfunction

    function automatic logic [63:0] entry_address(input logic [63:0] base,
                                                  input logic [63:0] addr,
                                                  input logic [remap_check_pkg::LVL_W-1:0] lvl);
        logic [63:0] idx;
        idx = (addr >> page_shift(lvl)) & remap_check_pkg::INDEX_MASK;
        return base + (idx << 3);
    endfunction

    function automatic logic [127:0] build_record(input logic        is_ir,
                                                  input logic        is_read,
                                                  input logic [1:0]  at,
                                                  input logic [7:0]  cause,
                                                  input logic [15:0] rid,
                                                  input logic [63:0] info);
        logic [127:0] r;
        r = '0; // see RL9
        if (!is_ir) begin
            r[remap_check_pkg::REC_TYPE_BIT] = is_read; // see RL10
            r[remap_check_pkg::REC_AT_LSB +: 2] = at; // see RL11
            r[63:remap_check_pkg::REC_INFO_LSB] = info[63:remap_check_pkg::REC_INFO_LSB]; // see RL14
        end else begin
            r[remap_check_pkg::REC_INDEX_LSB +: 16] = info[15:0]; // see RL15
        end
        r[remap_check_pkg::REC_CAUSE_LSB +: 8] = cause; // see RL12
        r[remap_check_pkg::REC_RID_LSB +: 16] = rid; // see RL13
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    logic        perm_read;
    logic        perm_write;
    logic        present;
    logic        denied;
    logic        size_ok;
    logic        dma_fault;
    logic [7:0]  cause;
    logic [63:0] frame;
    logic [63:0] off;
    logic [1:0]  events;

    always_comb begin
        s_nxt = s_r;
        s_nxt.resp_valid = 1'b0;
        s_nxt.fault_valid = 1'b0;
        dma_fault = 1'b0;
        cause = remap_check_pkg::CAUSE_NOT_PRESENT;
        events = 2'b00;
        // bits 6:2 of the entry are never looked at below
        perm_read = mem_data[remap_check_pkg::PTE_READ_BIT]; // see RL5
        perm_write = mem_data[remap_check_pkg::PTE_WRITE_BIT];
        present = perm_read | perm_write;
        frame = mem_data & HOST_MASK & ~remap_check_pkg::FRAME_LOW_MASK; // see RL16
        off = low_mask(s_r.lvl);
        if (s_r.is_write) begin
            denied = !perm_write; // see RL6
        end else begin
            // zero length reads to write only pages pass when allowed
            denied = !perm_read && !(s_r.ctrl[remap_check_pkg::CTRL_ZERO_LEN_READ]
                     && s_r.zero_len && perm_write); // see RL7 see RL8
        end
        case (s_r.lvl)
            3'd1: size_ok = s_r.ctrl[remap_check_pkg::CTRL_SUPER_2M]; // see RL2
            3'd2: size_ok = s_r.ctrl[remap_check_pkg::CTRL_SUPER_1G];
            default: size_ok = 1'b0;
        endcase

        case (s_r.st)
            remap_check_pkg::WALK_IDLE: begin
                if (req_valid) begin
                    s_nxt.addr = req_addr;
                    s_nxt.is_write = req_write;
                    s_nxt.zero_len = req_zero_len;
                    s_nxt.at = req_at;
                    s_nxt.rid = req_requester_identifier;
                    s_nxt.lvl = remap_check_pkg::LVL_W'(LEVELS - 1);
                    s_nxt.mem_addr = entry_address(s_r.root & HOST_MASK, req_addr,
                                                   remap_check_pkg::LVL_W'(LEVELS - 1));
                    s_nxt.st = remap_check_pkg::WALK_FETCH;
                end
            end
            remap_check_pkg::WALK_FETCH: begin
                if (mem_ready) begin
                    s_nxt.st = remap_check_pkg::WALK_WAIT;
                end
            end
            remap_check_pkg::WALK_WAIT: begin
                if (mem_valid) begin
                    s_nxt.st = remap_check_pkg::WALK_IDLE;
                    if (!present) begin
                        dma_fault = 1'b1;
                    end else if (denied) begin
                        dma_fault = 1'b1; // see RL17
                        cause = s_r.is_write ? remap_check_pkg::CAUSE_WRITE_DENY
                                             : remap_check_pkg::CAUSE_READ_DENY;
                    end else if (s_r.lvl == '0) begin
                        // 4KB leaf: the super page bit is don't care here
                        s_nxt.resp_valid = 1'b1; // see RL4
                        s_nxt.resp_ok = 1'b1;
                        s_nxt.resp_hpa = frame | (s_r.addr & off);
                    end else if (mem_data[remap_check_pkg::PTE_SUPER_PAGE]) begin // see RL3
                        if (size_ok) begin
                            s_nxt.resp_valid = 1'b1; // see RL1
                            s_nxt.resp_ok = 1'b1;
                            s_nxt.resp_hpa = (frame & ~off) | (s_r.addr & off);
                        end else begin
                            dma_fault = 1'b1; // see RL2
                            cause = remap_check_pkg::CAUSE_RESERVED;
                        end
                    end else begin
                        s_nxt.lvl = s_r.lvl - 1'b1; // see RL1
                        s_nxt.mem_addr = entry_address(frame, s_r.addr, s_r.lvl - 1'b1);
                        s_nxt.st = remap_check_pkg::WALK_FETCH;
                    end
                end
            end
            default: s_nxt.st = remap_check_pkg::WALK_IDLE;
        endcase

        ////////////////////////////////////////////////////////////////////////////////
        // a walk fault takes the record slot; the interrupt side waits one cycle
        ir_fault_ready = !dma_fault;
        if (dma_fault) begin
            s_nxt.resp_valid = 1'b1; // see RL17
            s_nxt.resp_ok = 1'b0;
            s_nxt.resp_hpa = '0;
            s_nxt.fault_valid = 1'b1;
            s_nxt.record = build_record(1'b0, !s_r.is_write, s_r.at, cause, s_r.rid,
                                        s_r.addr);
            events[remap_check_pkg::STAT_DMA_FAULT] = 1'b1;
        end else if (ir_fault_valid) begin
            s_nxt.fault_valid = 1'b1;
            s_nxt.record = build_record(1'b1, 1'b0, 2'b00, ir_fault_cause,
                                        ir_requester_identifier, {48'h0000_0000_0000, ir_index});
            events[remap_check_pkg::STAT_IR_FAULT] = 1'b1;
        end

        ////////////////////////////////////////////////////////////////////////////////
        // register port; a status read clears, but a same-cycle event still lands
        if (reg_write) begin
            case (reg_addr)
                remap_check_pkg::REG_CTRL:    s_nxt.ctrl = reg_wdata;
                remap_check_pkg::REG_ROOT_LO: s_nxt.root[31:0] = reg_wdata;
                remap_check_pkg::REG_ROOT_HI: s_nxt.root[63:32] = reg_wdata;
                remap_check_pkg::REG_MASK:    s_nxt.mask = reg_wdata[1:0];
                default: ;
            endcase
        end
        s_nxt.rdata = '0;
        if (reg_read) begin
            case (reg_addr)
                remap_check_pkg::REG_CTRL:    s_nxt.rdata = s_r.ctrl;
                remap_check_pkg::REG_ROOT_LO: s_nxt.rdata = s_r.root[31:0];
                remap_check_pkg::REG_ROOT_HI: s_nxt.rdata = s_r.root[63:32];
                remap_check_pkg::REG_STATUS:
                    s_nxt.rdata = {29'h0000_0000, s_r.st != remap_check_pkg::WALK_IDLE,
                                   s_r.status};
                remap_check_pkg::REG_MASK:    s_nxt.rdata = {30'h0000_0000, s_r.mask};
                remap_check_pkg::REG_REC0:    s_nxt.rdata = s_r.record[31:0];
                remap_check_pkg::REG_REC1:    s_nxt.rdata = s_r.record[63:32];
                remap_check_pkg::REG_REC2:    s_nxt.rdata = s_r.record[95:64];
                remap_check_pkg::REG_REC3:    s_nxt.rdata = s_r.record[127:96];
                default:                      s_nxt.rdata = '0;
            endcase
        end
        if (reg_read && reg_addr == remap_check_pkg::REG_STATUS) begin
            s_nxt.status = events;
        end else begin
            s_nxt.status = s_r.status | events;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            s_r <= '0;
            s_r.ctrl <= remap_check_pkg::CTRL_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign req_ready = (s_r.st == remap_check_pkg::WALK_IDLE);
    assign mem_req = (s_r.st == remap_check_pkg::WALK_FETCH);
    assign mem_addr = s_r.mem_addr;
    assign resp_valid = s_r.resp_valid;
    assign resp_ok = s_r.resp_ok;
    assign resp_hpa = s_r.resp_hpa;
    assign fault_valid = s_r.fault_valid;
    assign fault_record = s_r.record;
    assign reg_rdata = s_r.rdata;
    assign irq = |(s_r.status & s_r.mask);
endmodule
`default_nettype wire

// *** design/remap_check_pkg.sv ***
// Functional notes
// (RL1) super page stops walk, forms address
// (RL2) unsupported super page size is reserved
// (RL3) super page examined only if permitted
// (RL4) super page ignored in 4KB leaves
// (RL5) software owned bits never affect translation
// (RL6) write bit clear blocks DMA writes
// (RL7) read bit clear blocks DMA reads
// (RL8) zero length reads skip read check
// (RL9) fault record 128 bits, reserved zero
// (RL10) record type bit: write 0, read 1
// (RL11) request address type copied into record
// (RL12) fault cause in bits 103:96
// (RL13) requester identifier in bits 79:64
// (RL14) page address in bits 63:12
// (RL15) interrupt index in bits 63:48
// (RL16) frame is page or next table
// (RL17) blocked request faults, rejects, records
package remap_check_pkg;
    ////////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {WALK_IDLE, WALK_FETCH, WALK_WAIT} walk_state_e;

    localparam int          LVL_W          = 3;
    localparam int          PAGE_SHIFT     = 12;
    localparam int          LEVEL_STRIDE   = 9;
    localparam logic [63:0] INDEX_MASK     = 64'h0000_0000_0000_01ff;
    localparam logic [63:0] FRAME_LOW_MASK = 64'h0000_0000_0000_0fff;
    ////////////////////////////////////////////////////////////////////////////////
    // entry bit positions
    localparam int PTE_READ_BIT   = 0;
    localparam int PTE_WRITE_BIT  = 1;
    localparam int PTE_SUPER_PAGE = 7;
    ////////////////////////////////////////////////////////////////////////////////
    // fault record layout
    localparam int REC_TYPE_BIT  = 126;
    localparam int REC_AT_LSB    = 124;
    localparam int REC_CAUSE_LSB = 96;
    localparam int REC_RID_LSB   = 64;
    localparam int REC_INFO_LSB  = 12;
    localparam int REC_INDEX_LSB = 48;
    ////////////////////////////////////////////////////////////////////////////////
    // fault causes
    localparam logic [7:0] CAUSE_NOT_PRESENT = 8'h01;
    localparam logic [7:0] CAUSE_WRITE_DENY  = 8'h02;
    localparam logic [7:0] CAUSE_READ_DENY   = 8'h03;
    localparam logic [7:0] CAUSE_RESERVED    = 8'h04;
    ////////////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_ROOT_LO = 8'h04;
    localparam logic [7:0] REG_ROOT_HI = 8'h08;
    localparam logic [7:0] REG_STATUS  = 8'h0c;
    localparam logic [7:0] REG_MASK    = 8'h10;
    localparam logic [7:0] REG_REC0    = 8'h14;
    localparam logic [7:0] REG_REC1    = 8'h18;
    localparam logic [7:0] REG_REC2    = 8'h1c;
    localparam logic [7:0] REG_REC3    = 8'h20;

    localparam int          CTRL_ZERO_LEN_READ = 0;
    localparam int          CTRL_SUPER_2M      = 1;
    localparam int          CTRL_SUPER_1G      = 2;
    localparam logic [31:0] CTRL_RESET         = 32'h0000_0000;
    localparam int          STAT_DMA_FAULT     = 0;
    localparam int          STAT_IR_FAULT      = 1;
    localparam int          STAT_BUSY          = 2;
endpackage

// *** tb/remap_check_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module remap_check_properties (
    input wire logic         clk_sys,
    input wire logic         reset_n,
    input wire logic         req_valid,
    input wire logic         req_ready,
    input wire logic [63:0]  req_addr,
    input wire logic         req_write,
    input wire logic [1:0]   req_at,
    input wire logic [15:0]  req_requester_identifier,
    input wire logic         resp_valid,
    input wire logic         resp_ok,
    input wire logic [63:0]  resp_hpa,
    input wire logic         ir_fault_valid,
    input wire logic         ir_fault_ready,
    input wire logic [7:0]   ir_fault_cause,
    input wire logic [15:0]  ir_index,
    input wire logic         fault_valid,
    input wire logic [127:0] fault_record
);
    // request fields captured at take; the bus may move on while the walk runs
    logic        wr_r;
    logic [1:0]  at_r;
    logic [15:0] rid_r;
    logic [63:0] addr_r;
    logic [7:0]  cause_r;
    logic [15:0] idx_r;
    always_ff @(posedge clk_sys) begin
        if (req_valid && req_ready) begin
            wr_r   <= req_write;
            at_r   <= req_at;
            rid_r  <= req_requester_identifier;
            addr_r <= req_addr;
        end
        if (ir_fault_valid && ir_fault_ready) begin
            cause_r <= ir_fault_cause;
            idx_r   <= ir_index;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // a record with a response is a walk fault, or an interrupt fault taken in the cycle a walk succeeds
    logic walk_fault;
    assign walk_fault = resp_valid && fault_valid;
    chk_reject_fault: assert property (resp_valid && !resp_ok |-> fault_valid && resp_hpa == 0)
        else $error("blocked walk without fault");
    chk_rec_zero: assert property (fault_valid |-> fault_record[127] == 0
        && fault_record[123:104] == 0 && fault_record[95:80] == 0 && fault_record[11:0] == 0)
        else $error("reserved record bits set");
    chk_type_bit: assert property (walk_fault |-> fault_record[126] == !wr_r)
        else $error("record type bit wrong");
    chk_at_copy: assert property (walk_fault |-> fault_record[125:124] == at_r)
        else $error("record address type wrong");
    chk_rid_copy: assert property (walk_fault |-> fault_record[79:64] == rid_r)
        else $error("record requester wrong");
    chk_page_addr: assert property (walk_fault |-> fault_record[63:12] == addr_r[63:12])
        else $error("record page address wrong");
    chk_write_deny: assert property (walk_fault
        && fault_record[103:96] == remap_check_pkg::CAUSE_WRITE_DENY |-> wr_r)
        else $error("write denial on a read");
    chk_read_deny: assert property (walk_fault
        && fault_record[103:96] == remap_check_pkg::CAUSE_READ_DENY |-> !wr_r)
        else $error("read denial on a write");
    chk_ir_record: assert property (ir_fault_valid && ir_fault_ready |-> ##[1:2]
        fault_valid && fault_record[63:48] == idx_r && fault_record[47:12] == 0
        && fault_record[103:96] == cause_r)
        else $error("interrupt fault record wrong");
    chk_walk_done: assert property (req_valid && req_ready |-> ##[3:60] resp_valid)
        else $error("walk did not finish");
    cover property (resp_valid && resp_ok);
    cover property (walk_fault);
    cover property (ir_fault_valid && ir_fault_ready);
endmodule
bind remap_check remap_check_properties chk (.clk_sys, .reset_n, .req_valid, .req_ready,
    .req_addr, .req_write, .req_at, .req_requester_identifier, .resp_valid, .resp_ok,
    .resp_hpa, .ir_fault_valid, .ir_fault_ready, .ir_fault_cause, .ir_index, .fault_valid,
    .fault_record);
`default_nettype wire

// *** tb/table_mem.sv ***
`timescale 1ns/100ps
`default_nettype none
module table_mem (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        slow,
    input wire logic        mem_req,
    input wire logic [63:0] mem_addr,
    output logic            mem_ready,
    output logic            mem_valid,
    output logic     [63:0] mem_data
);
    // two tables picked by address bit 12: clear selects the upper level, set the leaf level
    logic [63:0] ent [0:1];
    logic        pend_r;
    logic        sel_r;
    logic        gate_r;
    assign mem_ready = mem_req && !pend_r && (gate_r || !slow);
    always_ff @(posedge clk_sys) begin
        gate_r    <= !gate_r;
        mem_valid <= 1'b0;
        // data lines flip outside a beat, so a stale entry reads inverted only on alternate cycles
        mem_data  <= ~mem_data;
        if (!reset_n) begin
            pend_r <= 1'b0;
            gate_r <= 1'b0;
        end else if (mem_req && mem_ready) begin
            pend_r <= 1'b1;
            sel_r  <= mem_addr[12];
        end else if (pend_r && (gate_r || !slow)) begin
            pend_r    <= 1'b0;
            mem_valid <= 1'b1;
            mem_data  <= ent[sel_r];
        end
    end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
    typedef struct packed {
        logic [63:0] e1, e0;
        logic wr, zl;
        logic [2:0] ctrl;
        logic [1:0] at;
        logic ok;
        logic [63:0] hpa;
        logic [7:0] cause;
        logic slow;
    } row_s;
    localparam logic [63:0] NT = 64'h0000_0000_0000_107f;
    localparam logic [63:0] LF = 64'h4000_0055_6677_8003;
    localparam logic [63:0] SUP = 64'h0000_0012_3460_0083;
    localparam logic [63:0] HP = 64'h0000_0055_6677_8abc;
    localparam logic [63:0] AD = 64'h0000_0000_0012_3abc;
    localparam logic [15:0] RID = 16'h3a5c;
    row_s rows [9] = '{
        '{NT, LF, 0, 0, 3'h0, 2'h0, 1, HP, 8'h00, 0},
        '{NT, 64'h0000_0055_6677_8001, 1, 0, 3'h0, 2'h1, 0, 0, 8'h02, 1},
        '{NT, 64'h0000_0055_6677_8002, 0, 0, 3'h0, 2'h2, 0, 0, 8'h03, 0},
        '{NT, 64'h0000_0055_6677_8002, 0, 1, 3'h1, 2'h3, 1, HP, 8'h00, 0},
        '{NT, 64'h0000_0055_6677_8002, 0, 1, 3'h0, 2'h0, 0, 0, 8'h03, 0},
        '{SUP, LF, 1, 0, 3'h2, 2'h0, 1, 64'h0000_0012_3472_3abc, 8'h00, 0},
        '{SUP, LF, 0, 0, 3'h4, 2'h1, 0, 0, 8'h04, 1},
        '{64'h0000_0000_0000_1080, LF, 1, 0, 3'h2, 2'h2, 0, 0, 8'h01, 0},
        '{NT, 64'h0000_0055_6677_80ff, 1, 0, 3'h0, 2'h3, 1, HP, 8'h00, 1}};
    logic clk_sys, reset_n, reg_write, reg_read, irq, req_valid, req_ready, req_write;
    logic req_zero_len, resp_valid, resp_ok, mem_req, mem_ready, mem_valid, slow;
    logic ir_fault_valid, ir_fault_ready, fault_valid;
    logic [7:0] reg_addr, ir_fault_cause;
    logic [31:0] reg_wdata, reg_rdata, rd;
    logic [1:0] req_at;
    logic [15:0] ir_requester_identifier, ir_index, req_requester_identifier;
    logic [63:0] resp_hpa, mem_addr, mem_data, req_addr;
    logic [127:0] fault_record;
    int failures, check_count, cycles;
    remap_check #(.LEVELS(2)) dut (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_write,
        .reg_read, .reg_rdata, .irq, .req_valid, .req_ready, .req_addr, .req_write,
        .req_zero_len, .req_at, .req_requester_identifier, .resp_valid, .resp_ok,
        .resp_hpa, .mem_req, .mem_addr, .mem_ready, .mem_valid, .mem_data, .ir_fault_valid,
        .ir_fault_ready, .ir_fault_cause, .ir_requester_identifier, .ir_index, .fault_valid,
        .fault_record);
    table_mem mem (.clk_sys, .reset_n, .slow, .mem_req, .mem_addr, .mem_ready, .mem_valid,
        .mem_data);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string nm);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (failures == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask
    task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        @(negedge clk_sys);
        check(reg_rdata, exp, nm);
    endtask
    // bounded wait on a one-cycle pulse, sampled mid-cycle
    task automatic await(ref logic s);
        for (int n = 0; n < 40; n++) begin
            @(negedge clk_sys);
            if (s === 1'b1) break;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        {reset_n, reg_write, reg_read, req_valid, req_write, req_zero_len, slow} = '0;
        {ir_fault_valid, reg_addr, reg_wdata, req_at, ir_fault_cause} = '0;
        {ir_requester_identifier, ir_index} = '0;
        req_addr = AD;
        req_requester_identifier = RID;
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(negedge clk_sys);
        check({req_ready, irq, resp_valid, resp_ok, fault_valid, mem_req}, 6'h20,
            "reset outputs");
        check(fault_record, 128'h0, "reset record");
        reg_chk(remap_check_pkg::REG_CTRL, 32'h0000_0000, "ctrl reset");
        for (int i = 0; i < 9; i++) begin
            mem.ent[0] = rows[i].e1;
            mem.ent[1] = rows[i].e0;
            slow <= rows[i].slow;
            reg_wr(remap_check_pkg::REG_CTRL, {29'h0, rows[i].ctrl});
            @(posedge clk_sys);
            req_valid <= 1'b1;
            {req_write, req_zero_len, req_at} <= {rows[i].wr, rows[i].zl, rows[i].at};
            @(posedge clk_sys);
            req_valid <= 1'b0;
            await(resp_valid);
            check({resp_valid, resp_ok, fault_valid},
                  {1'b1, rows[i].ok, !rows[i].ok}, "resp ok");
            check(resp_hpa, rows[i].hpa, "resp hpa");
            if (!rows[i].ok) check(fault_record, {1'b0, !rows[i].wr, rows[i].at, 20'h0,
                rows[i].cause, 16'h0, RID, AD[63:12], 12'h0}, "dma record");
        end
        reg_chk(remap_check_pkg::REG_STATUS, 32'h0000_0001, "status after faults");
        reg_chk(remap_check_pkg::REG_STATUS, 32'h0000_0000, "status cleared");
        reg_chk(8'h40, 32'h0000_0000, "unmapped read");
        reg_wr(remap_check_pkg::REG_MASK, 32'h0000_0002);
        @(posedge clk_sys);
        ir_fault_valid <= 1'b1;
        {ir_fault_cause, ir_requester_identifier, ir_index} <= {8'h25, 16'h1234, 16'hbeef};
        @(posedge clk_sys);
        ir_fault_valid <= 1'b0;
        await(fault_valid);
        check(fault_valid, 1'b1, "ir pulse");
        check(fault_record, {32'h0000_0025, 16'h0, 16'h1234, 16'hbeef, 48'h0}, "ir rec");
        @(negedge clk_sys);
        check(irq, 1'b1, "irq raised");
        reg_chk(remap_check_pkg::REG_STATUS, 32'h0000_0002, "ir status");
        check(irq, 1'b0, "irq cleared");
        reg_chk(remap_check_pkg::REG_REC2, 32'h0000_1234, "record word");
        // reset in mid-walk: the walker and the table model must both drop back
        @(posedge clk_sys);
        req_valid <= 1'b1;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        reset_n <= 1'b0;
        @(posedge clk_sys);
        reset_n <= 1'b1;
        @(negedge clk_sys);
        check({req_ready, irq, resp_valid, mem_req}, 4'h8, "mid-walk reset");
        reg_chk(remap_check_pkg::REG_CTRL, 32'h0000_0000, "ctrl after reset");
        // new address and requester, so the record must copy the request itself
        mem.ent[0] = NT;
        mem.ent[1] = 64'h0000_0055_6677_8001;
        reg_wr(remap_check_pkg::REG_MASK, 32'h0000_0001);
        reg_chk(remap_check_pkg::REG_MASK, 32'h0000_0001, "mask readback");
        @(posedge clk_sys);
        req_valid <= 1'b1;
        {req_write, req_at, req_addr, req_requester_identifier} <=
            {3'h5, 64'h0000_0000_0040_5123, 16'h0c31};
        @(posedge clk_sys);
        req_valid <= 1'b0;
        await(resp_valid);
        check({resp_valid, resp_ok, irq}, 3'h5, "fault after reset");
        check(fault_record, {4'h1, 20'h0, 8'h02, 16'h0, 16'h0c31,
            52'h0_0000_0000_0405, 12'h0}, "second record");
        reg_wr(remap_check_pkg::REG_ROOT_HI, 32'h0000_00a5);
        reg_chk(remap_check_pkg::REG_ROOT_HI, 32'h0000_00a5, "root readback");
        complete_run();
    end
endmodule
`default_nettype wire
